// *** rtl/gpb_host_port.v ***
`timescale 1ns/1ps
`include "gpb_consts.vh"

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module gpb_fifo #(
  parameter W = 9,
  parameter D = 8,
  parameter AW = 3
) (
  // Clock, reset, enable, clear
  input wire clock_in,
  input wire reset_n_in,
  input wire ce_in,
  input wire clear_in,
  // Fill side
  input wire in_valid_in,
  input wire [W-1:0] in_data_in,
  output wire in_ready_out,
  // Drain side
  output wire out_valid_out,
  output wire [W-1:0] out_data_out,
  input wire out_ready_in
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  assign in_ready_out = (count_reg != D[AW:0]);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_ready_in & out_valid_out;

  always @(posedge clock_in) begin
    if (ce_in && push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else if (ce_in) begin
      if (clear_in) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
      end else begin
        if (push) begin
          wr_ptr_reg <= (wr_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          rd_ptr_reg <= (rd_ptr_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
          count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end
endmodule // gpb_fifo

module gpb_host_port #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock, reset, enable
  input wire clock_in,
  input wire reset_n_in,
  input wire ce_in,
  input wire ref_clk_in,
  // Host port
  input wire cs_n_in,
  input wire rd_n_in,
  input wire wr_n_in,
  input wire [2:0] reg_select_in,
  input wire [7:0] host_data_in,
  output wire [7:0] host_data_out,
  output wire host_data_oe_out,
  output wire dma_req_out,
  input wire dma_ack_n_in,
  output wire irq_out,
  // Transceiver controls
  output wire xcvr_dir_ctl_a_out,
  output reg xcvr_dir_ctl_b_out,
  output reg xcvr_dir_ctl_c_out,
  // Instrument bus
  input wire [7:0] dio_in,
  output wire [7:0] dio_out,
  output wire dio_oe_out,
  input wire dav_in,
  output wire dav_out,
  output wire dav_oe_out,
  input wire nrfd_in,
  output wire nrfd_out,
  output wire nrfd_oe_out,
  input wire ndac_in,
  output wire ndac_out,
  output wire ndac_oe_out,
  input wire eoi_in,
  output wire eoi_out,
  output wire eoi_oe_out,
  input wire srq_in,
  output wire srq_out,
  output wire srq_oe_out,
  input wire atn_in,
  input wire ifc_in,
  input wire ren_in
);
  localparam S_IDLE = 3'b001;
  localparam S_SET = 3'b010;
  localparam S_DAV = 3'b100;
  localparam A_WAIT = 2'b01;
  localparam A_ACC = 2'b10;

  // ----------------------------------------
  // Host strobes
  // ----------------------------------------
  reg rd_prev_reg;
  reg wr_prev_reg;
  reg [7:0] rdata_reg;
  wire dma_sel = ~dma_ack_n_in;
  wire rd_act = ~rd_n_in & (~cs_n_in | dma_sel);
  wire wr_act = ~wr_n_in & (~cs_n_in | dma_sel);
  wire rd_start = rd_act & ~rd_prev_reg;
  wire wr_start = wr_act & ~wr_prev_reg;
  wire [2:0] sel = dma_sel ? `GPB_R_DATA : reg_select_in;
  wire rd_data = rd_start & (sel == `GPB_R_DATA);
  wire wr_data = wr_start & (sel == `GPB_R_DATA);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] din_reg;
  reg [7:0] isr1_reg;
  reg [7:0] isr2_reg;
  reg [7:0] imr1_reg;
  reg [7:0] imr2_reg;
  reg [7:0] spm_reg;
  reg [7:0] amode_reg;
  reg [7:0] cpt_reg;
  reg [3:0] freq_reg;
  reg [4:0] auxb_reg;
  reg seoi_reg;
  reg soft_rst_reg;
  reg irq_reg;
  reg lok_reg;
  reg rem_reg;
  reg srq_prev_reg;
  reg [7:0] set1;
  reg [7:0] set2;
  reg [7:0] clr1;
  reg [7:0] clr2;

  wire talk = amode_reg[`GPB_B_TON];
  wire listen = amode_reg[`GPB_B_LON];
  wire atn_act = ~atn_in;
  wire if_clr = soft_rst_reg | ~ifc_in;
  wire poll = atn_act & ~eoi_in;

  // ----------------------------------------
  // Reference clock edges
  // ----------------------------------------
  reg ref_s1_reg;
  reg ref_s2_reg;
  reg ref_s3_reg;
  wire ref_edge = ref_s2_reg & ~ref_s3_reg;
  wire [3:0] freq_eff = (freq_reg == 4'h0) ? 4'h1 : freq_reg;
  wire [4:0] t1_edges = {1'b0, freq_eff} * `GPB_T1_US;

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  reg [2:0] src_st_reg;
  reg [4:0] src_cnt_reg;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [8:0] fifo_head;
  wire push_req = wr_data;
  wire src_pop = src_st_reg[2] & ndac_in & ~atn_act & ~if_clr;

  gpb_fifo #(
    .W(9),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .clear_in(soft_rst_reg),
    .in_valid_in(push_req),
    .in_data_in({seoi_reg, host_data_in}),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_head),
    .out_ready_in(src_pop)
  );

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_st_reg <= S_IDLE;
      src_cnt_reg <= 5'h00;
    end else if (ce_in) begin
      if (if_clr || atn_act) begin
        src_st_reg <= S_IDLE;
      end else begin
        case (src_st_reg)
          S_IDLE: begin
            src_cnt_reg <= 5'h00;
            if (talk && fifo_out_valid) begin
              src_st_reg <= S_SET;
            end
          end
          S_SET: begin
            if (ref_edge && src_cnt_reg < t1_edges) begin
              src_cnt_reg <= src_cnt_reg + 5'h01;
            end
            if (src_cnt_reg >= t1_edges && nrfd_in) begin
              src_st_reg <= S_DAV;
            end
          end
          S_DAV: begin
            if (ndac_in) begin
              src_st_reg <= S_IDLE;
            end
          end
          default: src_st_reg <= S_IDLE;
        endcase
      end
    end
  end

  wire src_busy = ~src_st_reg[0];
  assign dio_out = ~fifo_head[7:0];
  assign dio_oe_out = src_busy;
  assign dav_out = 1'b0;
  assign dav_oe_out = src_st_reg[2];
  assign eoi_out = 1'b0;
  assign eoi_oe_out = src_busy & fifo_head[8];

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  reg [1:0] acc_st_reg;
  reg [7:0] rx_byte_reg;
  reg rx_eoi_reg;
  reg rx_atn_reg;
  reg rx_pulse_reg;
  wire part = (listen | atn_act) & ~poll;
  wire acc_rdy = atn_act | ~isr1_reg[`GPB_B_DI];

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_st_reg <= A_WAIT;
      rx_byte_reg <= `GPB_RST_BYTE;
      rx_eoi_reg <= 1'b0;
      rx_atn_reg <= 1'b0;
      rx_pulse_reg <= 1'b0;
    end else if (ce_in) begin
      rx_pulse_reg <= 1'b0;
      if (if_clr) begin
        acc_st_reg <= A_WAIT;
      end else begin
        case (acc_st_reg)
          A_WAIT: begin
            if (part && acc_rdy && !dav_in) begin
              acc_st_reg <= A_ACC;
              rx_byte_reg <= ~dio_in;
              rx_eoi_reg <= ~eoi_in;
              rx_atn_reg <= atn_act;
              rx_pulse_reg <= 1'b1;
            end
          end
          A_ACC: begin
            if (dav_in || !part) begin
              acc_st_reg <= A_WAIT;
            end
          end
          default: acc_st_reg <= A_WAIT;
        endcase
      end
    end
  end

  assign nrfd_out = 1'b0;
  assign nrfd_oe_out = part & (acc_st_reg[1] | ~acc_rdy);
  assign ndac_out = 1'b0;
  assign ndac_oe_out = part & acc_st_reg[0];

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  wire rx_data = rx_pulse_reg & ~rx_atn_reg;
  wire rx_cmd = rx_pulse_reg & rx_atn_reg;
  wire [6:0] msg = rx_byte_reg[6:0];
  wire is_get = rx_cmd & listen & (msg == `GPB_MSG_GET);
  wire is_dcl = rx_cmd & ((msg == `GPB_MSG_DCL) | (listen & (msg == `GPB_MSG_SDC)));
  wire is_llo = rx_cmd & (msg == `GPB_MSG_LLO);
  wire is_cpt = rx_cmd & ~is_get & ~is_dcl & ~is_llo;
  wire rem_now = ~ren_in;
  wire lok_next = is_llo ? 1'b1 : (rem_now & lok_reg);
  wire srq_fall = srq_prev_reg & ~srq_in;
  wire [7:0] aw_mode = host_data_in;
  wire amode_chg = wr_start & (sel == `GPB_R_ADDR) & (aw_mode[7:6] != amode_reg[7:6]);
  wire talk_rise = wr_start & (sel == `GPB_R_ADDR) & aw_mode[`GPB_B_TON] & ~talk;

  always @* begin
    set1 = 8'h00;
    set1[`GPB_B_CPT] = is_cpt & auxb_reg[`GPB_B_CPTEN];
    set1[`GPB_B_DET] = is_get;
    set1[`GPB_B_END] = rx_data & rx_eoi_reg;
    set1[`GPB_B_DEC] = is_dcl;
    set1[`GPB_B_ERR] = push_req & ~fifo_in_ready;
    set1[`GPB_B_DO] = src_pop | talk_rise;
    set1[`GPB_B_DI] = rx_data;
    set2 = 8'h00;
    set2[`GPB_B_SRQI] = srq_fall;
    set2[`GPB_B_LOCKOUT_CHANGE] = lok_next ^ lok_reg;
    set2[`GPB_B_REMOTE_CHANGE] = rem_now ^ rem_reg;
    set2[`GPB_B_ADDR_STATE_CHANGE] = amode_chg;
    clr1 = (rd_start && sel == `GPB_R_ISR1) ? 8'hFF : 8'h00;
    clr1[`GPB_B_DI] = clr1[`GPB_B_DI] | rd_data;
    clr1[`GPB_B_DO] = clr1[`GPB_B_DO] | wr_data;
    clr2 = (rd_start && sel == `GPB_R_ISR2) ? 8'hFF : 8'h00;
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      din_reg <= `GPB_RST_BYTE;
      isr1_reg <= `GPB_RST_BYTE;
      isr2_reg <= `GPB_RST_BYTE;
      imr1_reg <= `GPB_RST_BYTE;
      imr2_reg <= `GPB_RST_BYTE;
      spm_reg <= `GPB_RST_BYTE;
      amode_reg <= `GPB_RST_BYTE;
      cpt_reg <= `GPB_RST_BYTE;
      freq_reg <= `GPB_RST_FREQ;
      auxb_reg <= `GPB_RST_AUXB;
      seoi_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      lok_reg <= 1'b0;
      rem_reg <= 1'b0;
      srq_prev_reg <= 1'b1;
    end else if (ce_in) begin
      soft_rst_reg <= 1'b0;
      srq_prev_reg <= srq_in;
      rem_reg <= rem_now;
      if (soft_rst_reg) begin
        din_reg <= `GPB_RST_BYTE;
        isr1_reg <= `GPB_RST_BYTE;
        isr2_reg <= `GPB_RST_BYTE;
        imr1_reg <= `GPB_RST_BYTE;
        imr2_reg <= `GPB_RST_BYTE;
        spm_reg <= `GPB_RST_BYTE;
        amode_reg <= `GPB_RST_BYTE;
        cpt_reg <= `GPB_RST_BYTE;
        freq_reg <= `GPB_RST_FREQ;
        auxb_reg <= `GPB_RST_AUXB;
        seoi_reg <= 1'b0;
        lok_reg <= 1'b0;
      end else begin
        // Set wins over clear
        isr1_reg <= (isr1_reg & ~clr1) | set1;
        isr2_reg <= ((isr2_reg & ~clr2) | set2) & `GPB_ISR2_EV;
        lok_reg <= lok_next;
        if (rx_data) begin
          din_reg <= rx_byte_reg;
        end
        if (is_cpt) begin
          cpt_reg <= rx_byte_reg;
        end
        if (push_req && fifo_in_ready) begin
          seoi_reg <= 1'b0;
        end
        if (wr_start) begin
          case (sel)
            3'h1: imr1_reg <= host_data_in;
            3'h2: imr2_reg <= host_data_in;
            3'h3: spm_reg <= host_data_in;
            3'h4: amode_reg <= host_data_in;
            3'h5: begin
              if (host_data_in[7:5] == `GPB_CNT_FREQ) begin
                freq_reg <= host_data_in[3:0];
              end
              if (host_data_in[7:5] == `GPB_CNT_AUXB) begin
                auxb_reg <= host_data_in[4:0];
              end
              if (host_data_in[7:5] == `GPB_CNT_CMD) begin
                if (host_data_in[4:0] == `GPB_CMD_CRST) begin
                  soft_rst_reg <= 1'b1;
                end
                if (host_data_in[4:0] == `GPB_CMD_SEOI) begin
                  seoi_reg <= 1'b1;
                end
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt and readback
  // ----------------------------------------
  wire int_any = |(isr1_reg & imr1_reg) | |(isr2_reg & imr2_reg & `GPB_ISR2_EV);
  wire [7:0] isr2_view = {int_any, isr2_reg[`GPB_B_SRQI], lok_reg, rem_reg,
                          isr2_reg[3:0]};
  reg [7:0] rmux;

  always @* begin
    case (sel)
      `GPB_R_DATA: rmux = din_reg;
      `GPB_R_ISR1: rmux = isr1_reg;
      `GPB_R_ISR2: rmux = isr2_view;
      `GPB_R_SPOLL: rmux = spm_reg;
      `GPB_R_ADDR: rmux = {1'b0, atn_act, 3'h0, listen, talk, 1'b0};
      `GPB_R_CPASS: rmux = cpt_reg;
      default: rmux = 8'h00;
    endcase
  end

  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
      rdata_reg <= `GPB_RST_BYTE;
      irq_reg <= 1'b0;
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
    end else if (ce_in) begin
      rd_prev_reg <= rd_act;
      wr_prev_reg <= wr_act;
      if (rd_start) begin
        rdata_reg <= rmux;
      end
      irq_reg <= int_any ^ auxb_reg[`GPB_B_INTLOW];
      ref_s1_reg <= ref_clk_in;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
    end
  end

  assign host_data_out = rdata_reg;
  assign host_data_oe_out = rd_act & rd_prev_reg;
  assign irq_out = irq_reg;
  // Request falls as soon as the acknowledge is seen
  assign dma_req_out = dma_ack_n_in & ((imr2_reg[`GPB_B_DMAI] & isr1_reg[`GPB_B_DI]) |
                       (imr2_reg[`GPB_B_DMAO] & isr1_reg[`GPB_B_DO] & fifo_in_ready));
  assign srq_out = 1'b0;
  assign srq_oe_out = spm_reg[`GPB_B_RSV];

  // ----------------------------------------
  // Transceiver controls
  // ----------------------------------------
  assign xcvr_dir_ctl_a_out = src_busy;

  always @* begin
    case ({amode_reg[`GPB_B_XCVR_MODE_HI], amode_reg[`GPB_B_XCVR_MODE_LO]})
      2'b00: begin
        xcvr_dir_ctl_b_out = src_busy;
        xcvr_dir_ctl_c_out = eoi_oe_out;
      end
      2'b01: begin
        xcvr_dir_ctl_b_out = src_busy;
        xcvr_dir_ctl_c_out = 1'b0;
      end
      2'b10: begin
        xcvr_dir_ctl_b_out = ~src_busy;
        xcvr_dir_ctl_c_out = srq_oe_out;
      end
      default: begin
        xcvr_dir_ctl_b_out = 1'b0;
        xcvr_dir_ctl_c_out = 1'b0;
      end
    endcase
  end
endmodule // gpb_host_port

// *** rtl/gpb_consts.vh ***
`ifndef GPB_CONSTS_VH
`define GPB_CONSTS_VH
// ----------------------------------------
// Register select codes
// ----------------------------------------
`define GPB_R_DATA 3'h0
`define GPB_R_ISR1 3'h1
`define GPB_R_ISR2 3'h2
`define GPB_R_SPOLL 3'h3
`define GPB_R_ADDR 3'h4
`define GPB_R_CPASS 3'h5
// ----------------------------------------
// First status byte bit positions
// ----------------------------------------
`define GPB_B_CPT 7
`define GPB_B_APT 6
`define GPB_B_DET 5
`define GPB_B_END 4
`define GPB_B_DEC 3
`define GPB_B_ERR 2
`define GPB_B_DO 1
`define GPB_B_DI 0
// ----------------------------------------
// Second status byte and second mask byte bit positions
// ----------------------------------------
`define GPB_B_INT 7
`define GPB_B_SRQI 6
`define GPB_B_LOK 5
`define GPB_B_REM 4
`define GPB_B_DMAO 5
`define GPB_B_DMAI 4
`define GPB_B_CO 3
`define GPB_B_LOCKOUT_CHANGE 2
`define GPB_B_REMOTE_CHANGE 1
`define GPB_B_ADDR_STATE_CHANGE 0
`define GPB_ISR2_EV 8'h4F
// ----------------------------------------
// Mode, poll, auxiliary and command register fields
// ----------------------------------------
`define GPB_B_TON 7
`define GPB_B_LON 6
`define GPB_B_XCVR_MODE_HI 5
`define GPB_B_XCVR_MODE_LO 4
`define GPB_B_RSV 6
`define GPB_B_CPTEN 0
`define GPB_B_INTLOW 3
`define GPB_CNT_CMD 3'h0
`define GPB_CNT_FREQ 3'h1
`define GPB_CNT_AUXB 3'h5
`define GPB_CMD_CRST 5'h02
`define GPB_CMD_SEOI 5'h06
// ----------------------------------------
// Bus commands received under attention
// ----------------------------------------
`define GPB_MSG_GET 7'h08
`define GPB_MSG_SDC 7'h04
`define GPB_MSG_DCL 7'h14
`define GPB_MSG_LLO 7'h11
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define GPB_RST_BYTE 8'h00
`define GPB_RST_FREQ 4'h8
`define GPB_RST_AUXB 5'h00
`define GPB_T1_US 5'h02
`endif

// *** dv/gpb_host_port_assertions.sv ***
`timescale 1ns/1ps
module gpb_host_port_chk #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Host side
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic dma_ack_n_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_out,
  input wire logic dma_req_out,
  input wire logic xcvr_dir_ctl_a_out,
  // Instrument bus
  input wire logic [7:0] dio_out,
  input wire logic dio_oe_out,
  input wire logic dav_out,
  input wire logic dav_oe_out,
  input wire logic nrfd_out,
  input wire logic ndac_out,
  input wire logic eoi_out,
  input wire logic srq_out,
  input wire logic nrfd_in,
  input wire logic ndac_in,
  input wire logic atn_in,
  input wire logic ifc_in
);
  wire rd_act = !rd_n_in && (!cs_n_in || !dma_ack_n_in);

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_rd_start;
    !rd_act ##1 rd_act;
  endsequence
  sequence s_dav_wait;
    dav_oe_out && !ndac_in && atn_in && ifc_in;
  endsequence

  // ----------------------------------------
  // Host port
  // ----------------------------------------
  AST_RD_ANSWER: assert property (s_rd_start ##1 rd_act |-> host_data_oe_out)
    else $error("read data late");
  AST_OE_ONLY_READ: assert property (host_data_oe_out |-> rd_act)
    else $error("bus driven idle");
  AST_DATA_HELD: assert property (host_data_oe_out ##1 host_data_oe_out |-> $stable(host_data_out))
    else $error("read data moved");
  AST_DRQ_ACK: assert property (!dma_ack_n_in |-> !dma_req_out)
    else $error("dma request held");

  // ----------------------------------------
  // Instrument bus
  // ----------------------------------------
  AST_DIR_A: assert property (dio_oe_out |-> xcvr_dir_ctl_a_out)
    else $error("direction low");
  AST_DAV_DATA: assert property (dav_oe_out |-> dio_oe_out)
    else $error("valid without data");
  AST_DAV_HOLD: assert property (s_dav_wait |=> dav_oe_out && $stable(dio_out))
    else $error("valid dropped early");
  AST_DAV_READY: assert property ($rose(dav_oe_out) |-> $past(nrfd_in))
    else $error("valid while not ready");
  AST_DAV_RELEASE: assert property (dav_oe_out && ndac_in |-> ##[1:3] !dav_oe_out)
    else $error("valid held late");
  AST_OC_LOW: assert property (!(dav_out || nrfd_out || ndac_out || eoi_out || srq_out))
    else $error("line driven high");
endmodule // gpb_host_port_chk

bind gpb_host_port gpb_host_port_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) i_gpb_host_port_chk (
  .clock_in, .reset_n_in, .cs_n_in, .rd_n_in, .dma_ack_n_in, .host_data_out, .host_data_oe_out,
  .dma_req_out, .xcvr_dir_ctl_a_out, .dio_out, .dio_oe_out, .dav_out, .dav_oe_out, .nrfd_out,
  .ndac_out, .eoi_out, .srq_out, .nrfd_in, .ndac_in, .atn_in, .ifc_in
);

// *** dv/gpb_bus_instr.sv ***
`timescale 1ns/1ps
module gpb_bus_instr (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Bus levels
  input wire logic dav_in,
  input wire logic nrfd_in,
  input wire logic ndac_in,
  input wire logic [7:0] dio_in,
  // Control from bench
  input wire logic tx_go_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_eoi_in,
  input wire logic slow_in,
  // Pulls, high pulls the line low; a low bit of dio_drv_out pulls its data line low
  output logic dav_pull_out,
  output logic nrfd_pull_out,
  output logic ndac_pull_out,
  output logic eoi_pull_out,
  output logic [7:0] dio_drv_out,
  // Status to bench
  output logic tx_busy_out,
  output logic [7:0] rx_byte_out,
  output logic [7:0] rx_count_out
);
  logic [1:0] l_st;
  logic [1:0] t_st;
  logic [4:0] dly;

  // ----------------------------------------
  // Acceptor and source handshakes
  // ----------------------------------------
  always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      l_st <= 2'h0;
      t_st <= 2'h0;
      dly <= 5'h00;
      dav_pull_out <= 1'b0;
      nrfd_pull_out <= 1'b0;
      ndac_pull_out <= 1'b1;
      eoi_pull_out <= 1'b0;
      dio_drv_out <= 8'hFF;
      tx_busy_out <= 1'b0;
      rx_byte_out <= 8'h00;
      rx_count_out <= 8'h00;
    end else begin
      case (l_st)
        2'h0: if (!dav_in) begin
          rx_byte_out <= ~dio_in;
          nrfd_pull_out <= 1'b1;
          dly <= slow_in ? 5'h14 : 5'h01;
          l_st <= 2'h1;
        end
        2'h1: if (dly == 5'h00) begin
          ndac_pull_out <= 1'b0;
          rx_count_out <= rx_count_out + 8'h01;
          l_st <= 2'h2;
        end else begin
          dly <= dly - 5'h01;
        end
        default: if (dav_in) begin
          ndac_pull_out <= 1'b1;
          nrfd_pull_out <= 1'b0;
          l_st <= 2'h0;
        end
      endcase
      case (t_st)
        2'h0: if (tx_go_in) begin
          tx_busy_out <= 1'b1;
          t_st <= 2'h1;
        end
        2'h1: if (nrfd_in) begin
          dio_drv_out <= ~tx_byte_in;
          eoi_pull_out <= tx_eoi_in;
          t_st <= 2'h2;
        end
        2'h2: begin
          dav_pull_out <= 1'b1;
          t_st <= 2'h3;
        end
        default: if (ndac_in) begin
          dav_pull_out <= 1'b0;
          eoi_pull_out <= 1'b0;
          dio_drv_out <= 8'hFF;
          tx_busy_out <= 1'b0;
          t_st <= 2'h0;
        end
      endcase
    end
  end
endmodule // gpb_bus_instr

// *** dv/tb_gpb_host_port.sv ***
`timescale 1ns/1ps
module tb_gpb_host_port;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock_in, reset_n_in, ref_clk, cs_n, rd_n, wr_n, dma_ack_n_n, atn_n, tx_go, tx_eoi, slow;
  logic [2:0] sel;
  logic [7:0] hd, tx_byte, rd_val, rx_want;
  wire [7:0] host_q, dio_q, m_dio, rx_byte, rx_cnt;
  wire oe, dma_req, irq, dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe;
  wire m_dav, m_nrfd, m_ndac, m_eoi, tx_busy;
  wire dav_l = ~(dav_oe | m_dav);
  wire nrfd_l = ~(nrfd_oe | m_nrfd);
  wire ndac_l = ~(ndac_oe | m_ndac);
  wire eoi_l = ~(eoi_oe | m_eoi);
  wire [7:0] dio_l = (dio_oe ? dio_q : 8'hFF) & m_dio;
  int bad_count, compares;

  gpb_host_port i_gpb_host_port (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .ce_in(1'b1), .ref_clk_in(ref_clk),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .reg_select_in(sel), .host_data_in(hd),
    .host_data_out(host_q), .host_data_oe_out(oe), .dma_req_out(dma_req), .dma_ack_n_in(dma_ack_n_n),
    .irq_out(irq), .xcvr_dir_ctl_a_out(), .xcvr_dir_ctl_b_out(), .xcvr_dir_ctl_c_out(),
    .dio_in(dio_l), .dio_out(dio_q), .dio_oe_out(dio_oe), .dav_in(dav_l), .dav_out(),
    .dav_oe_out(dav_oe), .nrfd_in(nrfd_l), .nrfd_out(), .nrfd_oe_out(nrfd_oe), .ndac_in(ndac_l),
    .ndac_out(), .ndac_oe_out(ndac_oe), .eoi_in(eoi_l), .eoi_out(), .eoi_oe_out(eoi_oe),
    .srq_in(~srq_oe), .srq_out(), .srq_oe_out(srq_oe), .atn_in(atn_n), .ifc_in(1'b1),
    .ren_in(1'b1)
  );

  gpb_bus_instr i_gpb_bus_instr (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .dav_in(dav_l), .nrfd_in(nrfd_l),
    .ndac_in(ndac_l), .dio_in(dio_l), .tx_go_in(tx_go), .tx_byte_in(tx_byte), .tx_eoi_in(tx_eoi),
    .slow_in(slow), .dav_pull_out(m_dav), .nrfd_pull_out(m_nrfd), .ndac_pull_out(m_ndac),
    .eoi_pull_out(m_eoi), .dio_drv_out(m_dio), .tx_busy_out(tx_busy), .rx_byte_out(rx_byte),
    .rx_count_out(rx_cnt)
  );

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial begin
    ref_clk = 1'b0;
    forever #62.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task close_out;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task settle;
    repeat (4) @(posedge clock_in);
    #1;
  endtask

  task reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    cs_n = 1'b0;
    wr_n = 1'b0;
    sel = a;
    hd = d;
    repeat (2) @(posedge clock_in);
    #1;
    cs_n = 1'b1;
    wr_n = 1'b1;
  endtask

  // dma picks the acknowledge path
  task reg_rd(input logic [2:0] a, input logic dma, output logic [7:0] d);
    int n;
    @(posedge clock_in);
    #1;
    sel = a;
    rd_n = 1'b0;
    if (dma) dma_ack_n_n = 1'b0;
    else cs_n = 1'b0;
    n = 0;
    do begin
      @(posedge clock_in) #1;
      n++;
    end while (oe !== 1'b1 && n < 8);
    if (oe !== 1'b1) begin
      bad_count++;
      $display("wrong value read answer expected 1 seen %b", oe);
      close_out;
    end
    d = host_q;
    #1;
    rd_n = 1'b1;
    cs_n = 1'b1;
    dma_ack_n_n = 1'b1;
  endtask

  // 0 byte count, 1 talker idle, 2 dma request
  task wait_for(input int w);
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge clock_in);
      #1;
      if ((w == 0 && rx_cnt === rx_want) || (w == 1 && tx_busy === 1'b0) || (w == 2 && dma_req === 1'b1))
        break;
    end
    if (n == 2000) begin
      bad_count++;
      $display("wrong value wait %0d expected done seen timeout", w);
      close_out;
    end
  endtask

  task send(input logic [7:0] b, input logic e);
    @(posedge clock_in);
    #1;
    tx_go = 1'b1;
    tx_byte = b;
    tx_eoi = e;
    @(posedge clock_in);
    #1;
    tx_go = 1'b0;
    wait_for(1);
    settle;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {cs_n, rd_n, wr_n, dma_ack_n_n, atn_n} = 5'h1F;
    {tx_go, tx_eoi, slow} = 3'h0;
    sel = 3'h0;
    hd = 8'h00;
    tx_byte = 8'h00;
    rx_want = 8'h00;
    bad_count = 0;
    compares = 0;
    reset_n_in = 1'b0;
    repeat (10) @(posedge clock_in);
    #1;
    reset_n_in = 1'b1;
    check("irq idle", {7'h00, irq}, 8'h00);
    check("oe idle", {7'h00, oe}, 8'h00);
    reg_rd(3'h1, 1'b0, rd_val);
    check("isr1 reset", rd_val, 8'h00);
    reg_rd(3'h2, 1'b0, rd_val);
    check("isr2 reset", rd_val, 8'h00);
    reg_wr(3'h3, 8'h5A);
    check("srq on", {7'h00, srq_oe}, 8'h01);
    reg_rd(3'h3, 1'b0, rd_val);
    check("poll mode", rd_val, 8'h5A);
    reg_wr(3'h3, 8'h1A);
    check("srq off", {7'h00, srq_oe}, 8'h00);
    reg_wr(3'h6, 8'hFF);
    reg_rd(3'h6, 1'b0, rd_val);
    check("read six", rd_val, 8'h00);
    reg_rd(3'h7, 1'b0, rd_val);
    check("read seven", rd_val, 8'h00);
    $display("test map done");

    reg_wr(3'h1, 8'h02);
    reg_wr(3'h4, 8'h80);
    settle;
    check("irq on", {7'h00, irq}, 8'h01);
    reg_wr(3'h5, 8'hA8);
    settle;
    check("irq low", {7'h00, irq}, 8'h00);
    reg_wr(3'h5, 8'hA0);
    settle;
    check("irq high", {7'h00, irq}, 8'h01);
    reg_rd(3'h1, 1'b0, rd_val);
    check("do status", rd_val, 8'h02);
    settle;
    check("irq off", {7'h00, irq}, 8'h00);
    slow = 1'b1;
    reg_wr(3'h0, 8'hA5);
    reg_wr(3'h0, 8'h3C);
    reg_rd(3'h1, 1'b0, rd_val);
    check("do cleared", rd_val, 8'h00);
    rx_want = 8'h01;
    wait_for(0);
    check("byte one", rx_byte, 8'hA5);
    rx_want = 8'h02;
    wait_for(0);
    check("byte two", rx_byte, 8'h3C);
    settle;
    reg_rd(3'h1, 1'b0, rd_val);
    check("do set", rd_val, 8'h02);
    slow = 1'b0;
    $display("test talker done");

    reg_wr(3'h4, 8'h40);
    send(8'hC3, 1'b1);
    check("irq masked", {7'h00, irq}, 8'h00);
    reg_rd(3'h0, 1'b0, rd_val);
    check("data in", rd_val, 8'hC3);
    reg_rd(3'h1, 1'b0, rd_val);
    check("end only", rd_val, 8'h10);
    $display("test listen done");

    reg_wr(3'h2, 8'h10);
    send(8'h5A, 1'b0);
    wait_for(2);
    reg_rd(3'h5, 1'b1, rd_val);
    check("dma data", rd_val, 8'h5A);
    settle;
    check("drq dropped", {7'h00, dma_req}, 8'h00);
    reg_wr(3'h2, 8'h00);
    $display("test dma done");

    atn_n = 1'b0;
    for (int i = 0; i < 2; i++) begin
      send(i ? 8'h14 : 8'h08, 1'b0);
      reg_rd(3'h1, 1'b0, rd_val);
      check("command", rd_val, i ? 8'h08 : 8'h20);
    end
    atn_n = 1'b1;
    $display("test atn done");

    reg_wr(3'h5, 8'h02);
    settle;
    reg_rd(3'h3, 1'b0, rd_val);
    check("soft reset", rd_val, 8'h00);
    $display("test reset done");
    close_out;
  end
endmodule // tb_gpb_host_port
